// [rtl/xpc_cal_ctrl.sv]
// What this block does
// - Mode from two pins: 00 gives 0, 01 gives 1, manual high gives 2.
// - Mode 1 recalibrates on every loss of lock, about 180 ms each.
// - Mode 2 disables calibration; range comes only from select, relock and reset pins.
// - Standalone: reference level picks range maximum (high) or minimum (low).
// - Mode 1 without reference keeps recalibrating, never stable.
// - Mode 0: no automatic restart; calibration only after reset, a software restart or leaving mode 2.
// - Mode 1: calibration after every reset and every unlock.
// - Manual low: low reset pin starts calibration then lock acquisition.
// - Manual high: six range bits, 5:4 from reset and relock pins.
// - Manual low: range pins ignored; calibration sets centre frequency.
// - Manual low: lock output is filtered and stable.
// - Manual high: lock output is the raw loop indication.
// - Error only while an upset persists; upset corrected silently.
// - Base 40 MHz; mode pin low 60/120, high 80/160 MHz.
// - Open range pins default: bit 3 high, bits 2..0 low.
//
// Decided for this implementation: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
module xpc_cal_ctrl
  import xpc_pkg::*;
#(
  parameter int CAL_CYCLES = CAL_CYC,
  parameter int ACQ_CYCLES = ACQ_CYC,
  parameter int FILT_CYCLES = FILT_CYC
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Configuration pins
  input wire xpc_pins_s pins,
  input wire logic freq_mode_sel,
  // Reference inputs
  input wire logic ref_clock_single_ended,
  input wire logic ref_clock_diff_pos,
  input wire logic ref_clock_diff_neg,
  // Analogue loop
  input wire logic pll_lock_raw,
  input wire logic vcxo_above_ref,
  output logic [RANGE_W-1:0] vcxo_range,
  output logic vcxo_pull_en,
  output logic vcxo_pull_max,
  // Status
  output logic locked,
  output logic seu_error,
  output xpc_freq_s out_freq
);

  typedef enum logic [2:0] {ST_CAL, ST_ACQ, ST_TRACK, ST_MANUAL} xpc_state_e;

  localparam int STEP_CYC = CAL_CYCLES / CAL_STEPS;

  ////////////////////////////////////////////////////////////////////////////
  // Pin decode
  xpc_mode_e mode;
  logic [3:0] range_lo;
  logic [RANGE_W-1:0] manual_range;
  logic ref_level;

  always_comb
  begin
    if (pins.manual_freq_control)
      mode = MODE_MANUAL;
    else if (pins.auto_relock_enable)
      mode = MODE_RELOCK;
    else
      mode = MODE_ONCE;
  end

  // Open pins fall back to their pull levels
  assign range_lo = (pins.vcxo_range_select & pins.range_pin_driven) |
                    (RANGE_PULL_RST & ~pins.range_pin_driven);
  assign manual_range = {pins.cal_reset_n, pins.auto_relock_enable, range_lo};
  // Receivers are ORed; an idle differential pair reads low
  assign ref_level = ref_clock_single_ended | (ref_clock_diff_pos & ~ref_clock_diff_neg);

  ////////////////////////////////////////////////////////////////////////////
  // Reference activity
  logic ref_prev_q, ref_prev_d;
  logic [7:0] gap_q, gap_d;
  logic ref_present;

  assign ref_present = gap_q < 8'(REF_GAP_CYC);

  always_comb
  begin
    ref_prev_d = ref_level;
    gap_d = gap_q;
    if (ref_level != ref_prev_q)
      gap_d = 8'h00;
    else if (ref_present)
      gap_d = gap_q + 8'h01;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ref_prev_q <= 1'b0;
      gap_q <= 8'(REF_GAP_CYC);
    end
    else
    begin
      ref_prev_q <= ref_prev_d;
      gap_q <= gap_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lock filter and protected calibration setting
  logic lock_filt;
  logic st_wr;
  logic [RANGE_W-1:0] st_wdata;
  logic [RANGE_W-1:0] cal_range;
  logic st_mismatch;
  logic inject_pulse;

  xpc_lock_filter #(.CNT(FILT_CYCLES)) u_filter (
    .hclk(hclk),
    .hresetn(hresetn),
    .raw(pll_lock_raw),
    .filtered(lock_filt)
  );

  xpc_tmr_store #(.W(RANGE_W)) u_store (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_en(st_wr),
    .wr_data(st_wdata),
    .inject(inject_pulse),
    .value(cal_range),
    .mismatch(st_mismatch)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Calibration sequencer
  xpc_state_e state_q, state_d;
  logic [31:0] tmr_q, tmr_d;
  logic [2:0] bit_q, bit_d;
  logic sw_cal_pulse;

  // Successive approximation: one range bit per step, MSB first
  always_comb
  begin
    state_d = state_q;
    tmr_d = tmr_q + 32'h1;
    bit_d = bit_q;
    st_wr = 1'b0;
    st_wdata = cal_range;
    case (state_q)
      ST_CAL:
      begin
        if (!pins.cal_reset_n || tmr_q == 32'h0)
        begin
          tmr_d = 32'h1;
          bit_d = 3'(RANGE_W - 1);
          st_wr = 1'b1;
          st_wdata = RANGE_W'(1) << (RANGE_W - 1);
        end
        else if (tmr_q == 32'(STEP_CYC))
        begin
          tmr_d = 32'h1;
          st_wr = 1'b1;
          st_wdata = cal_range;
          if (vcxo_above_ref)
            st_wdata[bit_q] = 1'b0;
          if (bit_q == 3'h0)
          begin
            state_d = ST_ACQ;
            tmr_d = 32'h0;
          end
          else
          begin
            bit_d = bit_q - 3'h1;
            st_wdata[bit_q - 3'h1] = 1'b1;
          end
        end
      end
      ST_ACQ:
      begin
        if (lock_filt)
          state_d = ST_TRACK;
        else if (tmr_q >= 32'(ACQ_CYCLES - 1) && mode == MODE_RELOCK)
        begin
          state_d = ST_CAL;
          tmr_d = 32'h0;
        end
      end
      ST_TRACK:
      begin
        tmr_d = 32'h0;
        if (!lock_filt)
          state_d = (mode == MODE_RELOCK) ? ST_CAL : ST_ACQ;
      end
      ST_MANUAL:
        tmr_d = 32'h0;
      default:
      begin
        state_d = ST_CAL;
        tmr_d = 32'h0;
      end
    endcase
    if (mode == MODE_MANUAL)
    begin
      state_d = ST_MANUAL;
      st_wr = 1'b0;
      tmr_d = 32'h0;
    end
    else if (state_q == ST_MANUAL || sw_cal_pulse || (!pins.cal_reset_n && state_q != ST_CAL))
    begin
      state_d = ST_CAL;
      tmr_d = 32'h0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q <= ST_CAL;
      tmr_q <= 32'h0;
      bit_q <= 3'(RANGE_W - 1);
    end
    else
    begin
      state_q <= state_d;
      tmr_q <= tmr_d;
      bit_q <= bit_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  logic [RANGE_W-1:0] range_d;
  logic locked_d, err_d, pull_en_d, pull_max_d;
  xpc_freq_s freq_d;

  always_comb
  begin
    range_d = (mode == MODE_MANUAL) ? manual_range : cal_range;
    locked_d = (mode == MODE_MANUAL) ? pll_lock_raw : (lock_filt && state_q == ST_TRACK);
    err_d = st_mismatch;
    pull_en_d = (mode == MODE_MANUAL) && !ref_present;
    pull_max_d = ref_level;
    freq_d.base = F_BASE_MHZ;
    freq_d.mid = freq_mode_sel ? F_MID_HI_MHZ : F_MID_LO_MHZ;
    freq_d.high = freq_mode_sel ? F_HIGH_HI_MHZ : F_HIGH_LO_MHZ;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      vcxo_range <= RANGE_RST;
      locked <= 1'b0;
      seu_error <= 1'b0;
      vcxo_pull_en <= 1'b0;
      vcxo_pull_max <= 1'b0;
      out_freq <= '0;
    end
    else
    begin
      vcxo_range <= range_d;
      locked <= locked_d;
      seu_error <= err_d;
      vcxo_pull_en <= pull_en_d;
      vcxo_pull_max <= pull_max_d;
      out_freq <= freq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, zero wait states
  logic wr_pend_q, wr_pend_d;
  logic [7:0] wr_addr_q, wr_addr_d;
  logic [31:0] rdata_d;
  logic [31:0] status_word;
  logic addr_ok;

  assign addr_ok = hsel && hready && htrans[1];
  assign status_word = {26'h0, ref_present, state_q == ST_CAL, seu_error, locked, 2'(mode)};

  always_comb
  begin
    wr_pend_d = addr_ok && hwrite;
    wr_addr_d = haddr[7:0];
    rdata_d = 32'h0;
    if (addr_ok && !hwrite && haddr[31:8] == 24'h0)
    begin
      case (haddr[7:0])
        ADDR_STATUS: rdata_d = status_word;
        ADDR_RANGE: rdata_d = {26'h0, vcxo_range};
        ADDR_FREQ: rdata_d = {8'h0, out_freq.high, out_freq.mid, out_freq.base};
        default: rdata_d = 32'h0;
      endcase
    end
  end

  // Control writes act as one-cycle pulses; the register reads as zero
  assign sw_cal_pulse = wr_pend_q && wr_addr_q == ADDR_CTRL && hwdata[CTRL_CAL_BIT];
  assign inject_pulse = wr_pend_q && wr_addr_q == ADDR_CTRL && hwdata[CTRL_INJ_BIT];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata <= 32'h0;
    end
    else
    begin
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      hrdata <= rdata_d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_mode_decode: assert property (@(posedge hclk) disable iff (!hresetn)
    status_word[1:0] == {pins.manual_freq_control, !pins.manual_freq_control && pins.auto_relock_enable})
    else $error("Mode decode wrong");

  chk_relock_start: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q == ST_TRACK && !lock_filt && mode == MODE_RELOCK && pins.cal_reset_n |=> state_q == ST_CAL)
    else $error("Mode 1 did not recalibrate on unlock");

  chk_manual_range: assert property (@(posedge hclk) disable iff (!hresetn)
    mode == MODE_MANUAL |=> vcxo_range == $past(manual_range) && !st_wr)
    else $error("Manual range not applied");

  chk_pull_level: assert property (@(posedge hclk) disable iff (!hresetn)
    1'b1 |=> vcxo_pull_max == $past(ref_level))
    else $error("Pull extreme does not follow reference level");

  chk_no_auto_restart: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q == ST_TRACK && mode == MODE_ONCE && !sw_cal_pulse && pins.cal_reset_n |=> state_q != ST_CAL)
    else $error("Mode 0 restarted calibration");

  chk_pin_reset: assert property (@(posedge hclk) disable iff (!hresetn)
    !pins.cal_reset_n && mode != MODE_MANUAL |=> state_q == ST_CAL ##0 tmr_q <= 32'h1)
    else $error("Reset pin did not restart calibration");

  chk_cal_range_kept: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q != ST_CAL && !inject_pulse && !st_mismatch |=> $stable(cal_range))
    else $error("Calibrated setting changed outside calibration");

  chk_raw_lock: assert property (@(posedge hclk) disable iff (!hresetn)
    mode == MODE_MANUAL |=> locked == $past(pll_lock_raw))
    else $error("Manual lock not raw");

  chk_error_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    inject_pulse |=> st_mismatch ##1 seu_error ##1 !seu_error)
    else $error("Error flag timing wrong");

  chk_freq_set: assert property (@(posedge hclk) disable iff (!hresetn)
    1'b1 |=> out_freq.base == F_BASE_MHZ && out_freq.high == ($past(freq_mode_sel) ? F_HIGH_HI_MHZ : F_HIGH_LO_MHZ))
    else $error("Output frequency set wrong");

  chk_pull_defaults: assert property (@(posedge hclk) disable iff (!hresetn)
    pins.range_pin_driven == 4'h0 && mode == MODE_MANUAL |=> vcxo_range[3:0] == RANGE_PULL_RST)
    else $error("Open range pins not at pull levels");

  cov_cal_done: cover property (@(posedge hclk) disable iff (!hresetn) state_q == ST_ACQ ##1 state_q == ST_TRACK);
  cov_relock: cover property (@(posedge hclk) disable iff (!hresetn) state_q == ST_TRACK ##1 state_q == ST_CAL);
  cov_upset: cover property (@(posedge hclk) disable iff (!hresetn) seu_error);
  cov_standalone: cover property (@(posedge hclk) disable iff (!hresetn) vcxo_pull_en && vcxo_pull_max);

endmodule : xpc_cal_ctrl

// [rtl/xpc_lock_filter.sv]
`timescale 1ns/1ps
module xpc_lock_filter
  import xpc_pkg::*;
#(
  parameter int CNT = FILT_CYC
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Lock
  input wire logic raw,
  output logic filtered
);

  logic filt_q, filt_d;
  logic [15:0] cnt_q, cnt_d;

  // Output moves only after the raw level has held for CNT cycles
  always_comb
  begin
    filt_d = filt_q;
    cnt_d = 16'h0000;
    if (raw != filt_q)
    begin
      if (cnt_q == 16'(CNT - 1))
        filt_d = raw;
      else
        cnt_d = cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      filt_q <= 1'b0;
      cnt_q <= 16'h0000;
    end
    else
    begin
      filt_q <= filt_d;
      cnt_q <= cnt_d;
    end
  end

  assign filtered = filt_q;

  chk_filter_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    $changed(filt_q) |-> $past(raw) == filt_q && $past(cnt_q) == 16'(CNT - 1))
    else $error("Filtered lock moved without a full hold");

endmodule : xpc_lock_filter

// [rtl/xpc_pkg.sv]
package xpc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_HZ = 25_000_000;
  localparam int CAL_TIME_MS = 180;
  localparam int CAL_CYC = CAL_TIME_MS * (CLK_HZ / 1000);
  localparam int ACQ_TIME_US = 250;
  localparam int ACQ_CYC = ACQ_TIME_US * (CLK_HZ / 1_000_000);
  localparam int FILT_TIME_US = 10;
  localparam int FILT_CYC = FILT_TIME_US * (CLK_HZ / 1_000_000);
  localparam int REF_GAP_NS = 1000;
  localparam int REF_GAP_CYC = REF_GAP_NS * (CLK_HZ / 1_000_000) / 1000;

  ////////////////////////////////////////////////////////////////////////////
  // Range select
  localparam int RANGE_W = 6;
  localparam int CAL_STEPS = 6;
  localparam logic [3:0] RANGE_PULL_RST = 4'h8;
  localparam logic [5:0] RANGE_RST = 6'h20;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_RANGE = 8'h08;
  localparam logic [7:0] ADDR_FREQ = 8'h0C;
  localparam int CTRL_CAL_BIT = 0;
  localparam int CTRL_INJ_BIT = 1;
  localparam int ST_MODE_LSB = 0;
  localparam int ST_LOCK_BIT = 2;
  localparam int ST_ERR_BIT = 3;
  localparam int ST_BUSY_BIT = 4;
  localparam int ST_REF_BIT = 5;
  localparam int FREQ_MID_LSB = 8;
  localparam int FREQ_HIGH_LSB = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Output frequency set, in MHz
  localparam logic [7:0] F_BASE_MHZ = 8'h28;
  localparam logic [7:0] F_MID_LO_MHZ = 8'h3C;
  localparam logic [7:0] F_HIGH_LO_MHZ = 8'h78;
  localparam logic [7:0] F_MID_HI_MHZ = 8'h50;
  localparam logic [7:0] F_HIGH_HI_MHZ = 8'hA0;

  typedef enum logic [1:0] {MODE_ONCE, MODE_RELOCK, MODE_MANUAL} xpc_mode_e;

  typedef struct packed {
    logic manual_freq_control;
    logic auto_relock_enable;
    logic cal_reset_n;
    logic [3:0] vcxo_range_select;
    logic [3:0] range_pin_driven;
  } xpc_pins_s;

  typedef struct packed {
    logic [7:0] base;
    logic [7:0] mid;
    logic [7:0] high;
  } xpc_freq_s;

endpackage : xpc_pkg

// [rtl/xpc_tmr_store.sv]
`timescale 1ns/1ps
module xpc_tmr_store
  import xpc_pkg::*;
#(
  parameter int W = RANGE_W
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Write side
  input wire logic wr_en,
  input wire logic [W-1:0] wr_data,
  input wire logic inject,
  // Read side
  output logic [W-1:0] value,
  output logic mismatch
);

  logic [W-1:0] copy_q [3];
  logic [W-1:0] copy_d [3];
  logic [W-1:0] voted;

  assign voted = (copy_q[0] & copy_q[1]) | (copy_q[0] & copy_q[2]) | (copy_q[1] & copy_q[2]);
  assign mismatch = (copy_q[0] != copy_q[1]) || (copy_q[0] != copy_q[2]);
  assign value = voted;

  // A flipped copy is outvoted and scrubbed the next cycle
  for (genvar i = 0; i < 3; i++)
  begin : g_copy
    always_comb
    begin
      copy_d[i] = wr_en ? wr_data : voted;
      if (inject && i == 0)
        copy_d[i] = voted ^ W'(1);
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
        copy_q[i] <= W'(RANGE_RST);
      else
        copy_q[i] <= copy_d[i];
    end
  end

  chk_scrub_one: assert property (@(posedge hclk) disable iff (!hresetn)
    mismatch && !inject |=> !mismatch)
    else $error("Upset not corrected in one cycle");

endmodule : xpc_tmr_store

// [tb/tb.sv]
`timescale 1ns/1ps
module tb
  import xpc_pkg::*;
;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic ref_on = 1, ref_lvl = 0, use_diff = 0, lock_on = 1, freq_mode_sel = 0;
  logic se, dp, dn, raw, above, pull_en, pull_max, locked, seu_error;
  logic [5:0] target = 6'h2B, vcxo_range;
  xpc_pins_s pins = '{1'b0, 1'b0, 1'b1, 4'h5, 4'hF};
  xpc_freq_s out_freq;
  int n_mismatch = 0, n_checks = 0, cycles = 0;

  xpc_cal_ctrl #(.CAL_CYCLES(60), .ACQ_CYCLES(40), .FILT_CYCLES(4)) DUT (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pins(pins),
    .freq_mode_sel(freq_mode_sel), .ref_clock_single_ended(se), .ref_clock_diff_pos(dp),
    .ref_clock_diff_neg(dn), .pll_lock_raw(raw), .vcxo_above_ref(above), .vcxo_range(vcxo_range),
    .vcxo_pull_en(pull_en), .vcxo_pull_max(pull_max), .locked(locked), .seu_error(seu_error),
    .out_freq(out_freq));

  xpc_board board (.hclk(hclk), .ref_on(ref_on), .ref_lvl(ref_lvl), .use_diff(use_diff), .lock_on(lock_on),
    .target(target), .vcxo_range(vcxo_range), .ref_clock_single_ended(se), .ref_clock_diff_pos(dp),
    .ref_clock_diff_neg(dn), .pll_lock_raw(raw), .vcxo_above_ref(above));

  always #20 hclk = ~hclk;

  ////////////////////////////////////////////////////////////////////////////
  // Hang guard
  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      n_mismatch++;
      finish_test();
    end
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Single AHB transfer; waits on hready, no fixed latency assumed
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus

  task wait_lock(input int n);
    for (int i = 0; i < n && locked !== 1'b1; i++) @(negedge hclk);
  endtask : wait_lock

  ////////////////////////////////////////////////////////////////////////////
  task t_cal0;
    wait_lock(200);
    chk(locked, 1);
    chk(vcxo_range, 6'h2B);
    @(posedge hclk);
    lock_on <= 0;
    repeat (2) @(posedge hclk);
    lock_on <= 1;
    repeat (8)
    begin
      @(negedge hclk);
      chk(locked, 1);
    end
    @(posedge hclk);
    lock_on <= 0;
    repeat (100) @(negedge hclk);
    chk(locked, 0);
    chk(vcxo_range, 6'h2B);
    bus(0, ADDR_STATUS, 0, rd);
    chk(rd[ST_BUSY_BIT], 0);
    chk(rd[1:0], MODE_ONCE);
    @(posedge hclk);
    lock_on <= 1;
    wait_lock(40);
    chk(locked, 1);
    @(posedge hclk);
    target <= 6'h07;
    pins.cal_reset_n <= 0;
    repeat (6) @(posedge hclk);
    pins.cal_reset_n <= 1;
    wait_lock(200);
    chk(locked, 1);
    chk(vcxo_range, 6'h07);
  endtask : t_cal0

  task t_seu;
    logic [5:0] keep;
    keep = vcxo_range;
    chk(seu_error, 0);
    bus(1, ADDR_CTRL, 32'h2, rd);
    for (int i = 0; i < 4 && seu_error !== 1'b1; i++) @(negedge hclk);
    chk(seu_error, 1);
    repeat (3) @(negedge hclk);
    chk(seu_error, 0);
    chk(vcxo_range, keep);
    bus(0, 32'h10, 0, rd);
    chk(rd, 0);
    chk(hresp, 0);
    bus(0, ADDR_RANGE, 0, rd);
    chk(rd[5:0], keep);
    // Software restart: busy, then the same setting found again
    bus(1, ADDR_CTRL, 32'h1, rd);
    bus(0, ADDR_STATUS, 0, rd);
    chk(rd[ST_BUSY_BIT], 1);
    wait_lock(200);
    chk(locked, 1);
    chk(vcxo_range, keep);
  endtask : t_seu

  task t_freq;
    logic [23:0] e;
    for (int m = 0; m < 2; m++)
    begin
      @(posedge hclk);
      freq_mode_sel <= m[0];
      e = {F_BASE_MHZ, m ? F_MID_HI_MHZ : F_MID_LO_MHZ, m ? F_HIGH_HI_MHZ : F_HIGH_LO_MHZ};
      repeat (3) @(negedge hclk);
      chk(out_freq, e);
      bus(0, ADDR_FREQ, 0, rd);
      chk(rd[23:0], {e[7:0], e[15:8], e[23:16]});
    end
  endtask : t_freq

  task t_relock;
    int n;
    logic [5:0] prev;
    @(posedge hclk);
    pins.auto_relock_enable <= 1;
    target <= 6'h11;
    repeat (8) @(negedge hclk);
    bus(0, ADDR_STATUS, 0, rd);
    chk(rd[1:0], MODE_RELOCK);
    chk(rd[ST_BUSY_BIT], 1);
    wait_lock(250);
    chk(locked, 1);
    chk(vcxo_range, 6'h11);
    @(posedge hclk);
    ref_on <= 0;
    lock_on <= 0;
    n = 0;
    prev = vcxo_range;
    repeat (300)
    begin
      @(negedge hclk);
      if (vcxo_range !== prev)
        n++;
      prev = vcxo_range;
    end
    chk(n > 6, 1);
    @(posedge hclk);
    ref_on <= 1;
    lock_on <= 1;
  endtask : t_relock

  task t_manual;
    logic prev;
    // Standalone source in mode 2 only, never mode 1
    @(posedge hclk);
    pins <= '{1'b1, 1'b0, 1'b1, 4'h6, 4'hF};
    target <= 6'h26;
    repeat (3) @(negedge hclk);
    chk(vcxo_range, 6'h26);
    bus(0, ADDR_STATUS, 0, rd);
    chk(rd[1:0], MODE_MANUAL);
    chk(rd[ST_BUSY_BIT], 0);
    prev = raw;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge hclk);
      lock_on <= i[0] ^ i[2];
      @(negedge hclk);
      chk(locked, prev);
      prev = raw;
    end
    @(posedge hclk);
    pins <= '{1'b1, 1'b1, 1'b0, 4'h6, 4'h0};
    repeat (3) @(negedge hclk);
    chk(vcxo_range, 6'h18);
    @(posedge hclk);
    ref_on <= 0;
    ref_lvl <= 1;
    repeat (40) @(negedge hclk);
    chk(pull_en, 1);
    chk(pull_max, 1);
    @(posedge hclk);
    ref_lvl <= 0;
    repeat (3) @(negedge hclk);
    chk(pull_max, 0);
    @(posedge hclk);
    use_diff <= 1;
    ref_lvl <= 1;
    repeat (3) @(negedge hclk);
    chk(pull_max, 1);
    chk(vcxo_range, 6'h18);
    @(posedge hclk);
    ref_on <= 1;
    lock_on <= 1;
    target <= 6'h2B;
    pins <= '{1'b0, 1'b0, 1'b1, 4'h5, 4'hF};
    repeat (3) @(negedge hclk);
    wait_lock(200);
    chk(vcxo_range, 6'h2B);
  endtask : t_manual

  task finish_test;
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test

  initial
  begin
    repeat (20) @(posedge hclk);
    hresetn <= 1;
    t_cal0();
    t_seu();
    t_freq();
    t_relock();
    t_manual();
    finish_test();
  end
endmodule : tb

// [tb/xpc_board.sv]
`timescale 1ns/1ps
module xpc_board
  import xpc_pkg::*;
(
  // Clock
  input wire logic hclk,
  // Scenario controls
  input wire logic ref_on,
  input wire logic ref_lvl,
  input wire logic use_diff,
  input wire logic lock_on,
  input wire logic [5:0] target,
  // Loop side
  input wire logic [RANGE_W-1:0] vcxo_range,
  output logic ref_clock_single_ended,
  output logic ref_clock_diff_pos,
  output logic ref_clock_diff_neg,
  output logic pll_lock_raw,
  output logic vcxo_above_ref
);
  logic ref_q = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Reference toggles when present, else sits at a chosen level
  always @(posedge hclk)
  begin
    ref_q <= ref_on ? ~ref_q : ref_lvl;
  end

  // Unused reference input parked, since the two are ORed
  assign ref_clock_single_ended = use_diff ? 1'b0 : ref_q;
  assign ref_clock_diff_pos = use_diff ? ref_q : 1'b0;
  assign ref_clock_diff_neg = use_diff ? ~ref_q : 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Loop locks only when the range is centred on the reference
  assign pll_lock_raw = lock_on && (vcxo_range == target);
  assign vcxo_above_ref = vcxo_range > target;
endmodule : xpc_board
